// ### design/addr_unit.sv
`timescale 1ns/1ps
module addr_unit (
	input  wire logic [31:0] idx0,
	input  wire logic [31:0] mod0,
	input  wire logic [31:0] len0,
	input  wire logic [31:0] base0,
	input  wire logic [31:0] idx1,
	input  wire logic [31:0] mod1,
	input  wire logic [31:0] len1,
	input  wire logic [31:0] base1,
	output logic      [31:0] next0,
	output logic      [31:0] next1
);
	// circular post-modify; zero length means linear
	function automatic logic [31:0] circ(input logic [31:0] i, m, l, b);
		logic [31:0] n;
		n = i + m;
		if (l != 32'h0 && n >= b + l)
			n = n - l;
		else if (l != 32'h0 && n < b)
			n = n + l;
		return n;
	endfunction : circ
	always_comb begin
		next0 = circ(idx0, mod0, len0, base0);
		next1 = circ(idx1, mod1, len1, base1);
	end
endmodule : addr_unit

// ### design/dsp_compute_datapath.sv
`timescale 1ns/1ps
// Functional notes
// - two 16-bit macs, two 40-bit accumulators, alus, video alus, 32-bit shifter
// - operands may be 8, 16 or 32 bits from the register file
// - eight 32-bit registers, also sixteen 16-bit halves
// - operands come only from register file or instruction constant
// - mac does 16x16 per cycle, signed/unsigned, rounding, saturation
// - alus do arithmetic and logic on 16 or 32 bits
// - extract, popcount, mod 2^32 multiply, divide step, saturate, round, sign bits
// - byte align/pack, clipped adds, 8-bit average, subtract-absolute-accumulate
// - compare-select and vector search
// - dual 16-bit operations per alu, quad with both; OP_QUAD here adds the high halves and subtracts the low halves
// - shifter does shifts, rotates, normalize, extract, deposit
// - pipeline interlocks on data dependencies, no software hazards
// - address unit makes two addresses per cycle
// - four circular sets of index/modify/length/base plus eight pointers
// - one 32-bit and two 16-bit instructions issue together; here each go write issues one instruction
module dsp_compute_datapath (
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);
	typedef struct packed {
		logic [7:0][31:0]  rf;
		logic [3:0][31:0]  idx;
		logic [3:0][31:0]  mdf;
		logic [3:0][31:0]  len;
		logic [3:0][31:0]  base;
		logic [7:0][31:0]  ptr;
		logic [1:0][39:0]  acc;
		dsp_pkg::ctrl_t    ctrl;
		dsp_pkg::ops_t     ops;
		logic [31:0]       imm;
		logic [31:0]       res;
		logic [31:0]       addr0;
		logic [31:0]       addr1;
		logic              busy;     // result write pending
		logic              stalls;   // interlock seen
		logic [31:0]       prdata;
		logic              pready;
		logic              pslverr;
	} state_t;

	state_t st, next_st;

	logic [39:0] mac0Next, mac1Next;
	logic [31:0] dag0, dag1;

	function automatic logic [15:0] half16(input logic [7:0][31:0] rf, input logic [3:0] i);
		return i[0] ? rf[i[3:1]][31:16] : rf[i[3:1]][15:0];
	endfunction : half16

	function automatic logic [7:0] clip8(input logic [8:0] s);
		return s[8] ? 8'hff : s[7:0];
	endfunction : clip8

	function automatic logic [15:0] sat16(input logic [16:0] s);
		if (s[16] != s[15])
			return s[16] ? 16'h8000 : 16'h7fff;
		return s[15:0];
	endfunction : sat16

	function automatic logic [5:0] lead(input logic [31:0] v);
		logic [5:0] n;
		n = 6'h0;
		for (int i = 30; i >= 0; i--) begin
			if (v[i] != v[31])
				break;
			n = n + 6'h1;
		end
		return n;
	endfunction : lead

	logic [31:0] opA, opB, r;
	logic [15:0] hA, hB;
	logic [5:0]  pc;
	logic [8:0]  diff;

	mac_unit u_mac0 (
		.sat     (st.ctrl.sat),
		.rnd     (st.ctrl.rnd),
		.unsig   (st.ctrl.unsig),
		.a       (opA[15:0]),
		.b       (opB[15:0]),
		.acc     (st.acc[0]),
		.accNext (mac0Next)
	);
	mac_unit u_mac1 (
		.sat     (st.ctrl.sat),
		.rnd     (st.ctrl.rnd),
		.unsig   (st.ctrl.unsig),
		.a       (opA[31:16]),
		.b       (opB[31:16]),
		.acc     (st.acc[1]),
		.accNext (mac1Next)
	);
	addr_unit u_dag (
		.idx0  (st.idx[st.ops.dagSet0]),
		.mod0  (st.mdf[st.ops.dagSet0]),
		.len0  (st.len[st.ops.dagSet0]),
		.base0 (st.base[st.ops.dagSet0]),
		.idx1  (st.idx[st.ops.dagSet1]),
		.mod1  (st.mdf[st.ops.dagSet1]),
		.len1  (st.len[st.ops.dagSet1]),
		.base1 (st.base[st.ops.dagSet1]),
		.next0 (dag0),
		.next1 (dag1)
	);

	// operand fetch: register file or constant only
	// full-width selects use the low three bits of the half index
	always_comb begin
		hA = half16(st.rf, st.ops.srcA);
		hB = half16(st.rf, st.ops.srcB);
		if (st.ctrl.half) begin
			opA = {16'h0, hA};
			opB = st.ctrl.useImm ? st.imm : {16'h0, hB};
		end else if (st.ctrl.byteW) begin
			opA = {24'h0, st.rf[st.ops.srcA[2:0]][7:0]};
			opB = st.ctrl.useImm ? st.imm : {24'h0, st.rf[st.ops.srcB[2:0]][7:0]};
		end else begin
			opA = st.rf[st.ops.srcA[2:0]];
			opB = st.ctrl.useImm ? st.imm : st.rf[st.ops.srcB[2:0]];
		end
		pc = 6'h0;
		for (int i = 0; i < 32; i++)
			pc = pc + {5'h0, opA[i]};
		diff = 9'h0;
		r = 32'h0;
		case (st.ctrl.op)
			dsp_pkg::OP_ADD:      r = opA + opB;
			dsp_pkg::OP_SUB:      r = opA - opB;
			dsp_pkg::OP_AND:      r = opA & opB;
			dsp_pkg::OP_OR:       r = opA | opB;
			dsp_pkg::OP_XOR:      r = opA ^ opB;
			dsp_pkg::OP_NOT:      r = ~opA;
			dsp_pkg::OP_ADD2:     r = {opA[31:16] + opB[31:16], opA[15:0] + opB[15:0]};
			dsp_pkg::OP_SUB2:     r = {opA[31:16] - opB[31:16], opA[15:0] - opB[15:0]};
			dsp_pkg::OP_QUAD:     r = {opA[31:16] + opB[31:16], opA[15:0] - opB[15:0]};
			dsp_pkg::OP_MUL32:    r = 32'(opA * opB);
			dsp_pkg::OP_POPCNT:   r = {26'h0, pc};
			dsp_pkg::OP_EXTRACT:  r = (opA >> opB[12:8]) & ((32'h1 << opB[4:0]) - 32'h1);
			dsp_pkg::OP_SIGNBITS: r = {26'h0, lead(opA)};
			dsp_pkg::OP_SAT16:    r = {16'h0, sat16({opA[15], opA[15:0]} + {opB[15], opB[15:0]})};
			dsp_pkg::OP_RND16:    r = {16'h0, 16'((opA + dsp_pkg::RND_HALF) >> 16)};
			dsp_pkg::OP_DIVS:     r = {opA[30:0], 1'b0} - (opA[31] ? 32'h0 : opB);
			dsp_pkg::OP_MIN:      r = ($signed(opA) < $signed(opB)) ? opA : opB;
			dsp_pkg::OP_MAX:      r = ($signed(opA) > $signed(opB)) ? opA : opB;
			dsp_pkg::OP_SEARCH:   r = {($signed(opA[31:16]) > $signed(opB[31:16])) ?
				opA[31:16] : opB[31:16], ($signed(opA[15:0]) > $signed(opB[15:0])) ?
				opA[15:0] : opB[15:0]};
			dsp_pkg::OP_ALIGN:    r = 32'({opA, opB} >> {opB[1:0], 3'h0});
			dsp_pkg::OP_PACK:     r = {opA[23:16], opA[7:0], opB[23:16], opB[7:0]};
			dsp_pkg::OP_ADDCLIP8: begin
				for (int i = 0; i < 4; i++)
					r[i*8 +: 8] = clip8({1'b0, opA[i*8 +: 8]} + {1'b0, opB[i*8 +: 8]});
			end
			dsp_pkg::OP_ADDCLIP16: r = {sat16({opA[31], opA[31:16]} + {opB[31], opB[31:16]}),
				sat16({opA[15], opA[15:0]} + {opB[15], opB[15:0]})};
			dsp_pkg::OP_AVG8: begin
				for (int i = 0; i < 4; i++) begin
					diff = {1'b0, opA[i*8 +: 8]} + {1'b0, opB[i*8 +: 8]} + 9'h1;
					r[i*8 +: 8] = diff[8:1];
				end
			end
			dsp_pkg::OP_SUBTRACT_ABSOLUTE_ACCUMULATE: begin
				// running sum builds on the last result, so chains need no reload
				r = st.res;
				for (int i = 0; i < 4; i++) begin
					diff = {1'b0, opA[i*8 +: 8]} - {1'b0, opB[i*8 +: 8]};
					r = r + {23'h0, diff[8] ? 9'(-diff) : diff};
				end
			end
			dsp_pkg::OP_SHL:     r = opA << opB[4:0];
			dsp_pkg::OP_ASHR:    r = $signed(opA) >>> opB[4:0];
			dsp_pkg::OP_ROT:     r = (opA << opB[4:0]) | (opA >> (6'd32 - {1'b0, opB[4:0]}));
			dsp_pkg::OP_NORM:    r = opA << lead(opA);
			dsp_pkg::OP_DEPOSIT: r = (opA & ~(32'hffff << opB[20:16]))
				| ({16'h0, opB[15:0]} << opB[20:16]);
			default:             r = st.res;
		endcase
	end

	logic apbAcc, apbWr, hazard, issue;
	always_comb begin
		apbAcc = psel && penable && !st.pready;
		apbWr = apbAcc && pwrite;
		// accesses, reads and writes alike, that overlap a pending result wait one cycle
		hazard = st.busy && apbAcc;
		issue = apbWr && !hazard && paddr == dsp_pkg::A_GO;
		next_st = st;
		next_st.pready = 1'b0;
		next_st.pslverr = 1'b0;
		// retire the issued instruction one cycle after its go write
		if (st.busy) begin
			next_st.busy = 1'b0;
			next_st.res = r;
			if (st.ctrl.op == dsp_pkg::OP_MAC) begin
				next_st.acc[0] = mac0Next;
				if (st.ctrl.mac1En)
					next_st.acc[1] = mac1Next;
			end else
				next_st.rf[st.ops.dst] = r;
			next_st.idx[st.ops.dagSet0] = dag0;
			if (st.ops.dagSet1 != st.ops.dagSet0)
				next_st.idx[st.ops.dagSet1] = dag1;
			next_st.addr0 = st.idx[st.ops.dagSet0];
			next_st.addr1 = st.idx[st.ops.dagSet1];
		end
		if (hazard)
			next_st.stalls = 1'b1;
		if (apbAcc && !hazard) begin
			next_st.pready = 1'b1;
			next_st.prdata = 32'h0;
			// a word register never answers a byte address
			if (issue)
				next_st.busy = 1'b1;
			else if (paddr[1:0] != 2'h0)
				next_st.pslverr = 1'b1;
			else if (apbWr) begin
				if (paddr == dsp_pkg::A_CTRL)
					next_st.ctrl = dsp_pkg::ctrl_t'(pwdata[$bits(dsp_pkg::ctrl_t)-1:0]);
				else if (paddr == dsp_pkg::A_OPS)
					next_st.ops = dsp_pkg::ops_t'(pwdata[$bits(dsp_pkg::ops_t)-1:0]);
				else if (paddr == dsp_pkg::A_IMM)
					next_st.imm = pwdata;
				else if (paddr == dsp_pkg::A_STAT)
					next_st.stalls = 1'b0;
				else if (paddr[11:8] == dsp_pkg::A_RF[11:8] && paddr[7:5] == 3'h0)
					next_st.rf[paddr[4:2]] = pwdata;
				else if (paddr[11:8] == dsp_pkg::A_DAG[11:8] && paddr[7:6] == 2'h0)
					case (paddr[3:2])
						2'h0: next_st.idx[paddr[5:4]] = pwdata;
						2'h1: next_st.mdf[paddr[5:4]] = pwdata;
						2'h2: next_st.len[paddr[5:4]] = pwdata;
						default: next_st.base[paddr[5:4]] = pwdata;
					endcase
				else if (paddr[11:8] == dsp_pkg::A_PTR[11:8] && paddr[7:5] == 3'h0)
					next_st.ptr[paddr[4:2]] = pwdata;
				else
					next_st.pslverr = 1'b1;
			end else begin
				if (paddr == dsp_pkg::A_CTRL)
					next_st.prdata = 32'(st.ctrl);
				else if (paddr == dsp_pkg::A_OPS)
					next_st.prdata = 32'(st.ops);
				else if (paddr == dsp_pkg::A_IMM)
					next_st.prdata = st.imm;
				else if (paddr == dsp_pkg::A_RES)
					next_st.prdata = st.res;
				else if (paddr == dsp_pkg::A_ACC0L)
					next_st.prdata = st.acc[0][31:0];
				else if (paddr == dsp_pkg::A_ACC0H)
					next_st.prdata = {24'h0, st.acc[0][39:32]};
				else if (paddr == dsp_pkg::A_ACC1L)
					next_st.prdata = st.acc[1][31:0];
				else if (paddr == dsp_pkg::A_ACC1H)
					next_st.prdata = {24'h0, st.acc[1][39:32]};
				else if (paddr == dsp_pkg::A_STAT)
					next_st.prdata = {30'h0, st.stalls, st.busy};
				else if (paddr == dsp_pkg::A_ADDR0)
					next_st.prdata = st.addr0;
				else if (paddr == dsp_pkg::A_ADDR1)
					next_st.prdata = st.addr1;
				else if (paddr[11:8] == dsp_pkg::A_RF[11:8] && paddr[7:5] == 3'h0)
					next_st.prdata = st.rf[paddr[4:2]];
				else if (paddr[11:8] == dsp_pkg::A_DAG[11:8] && paddr[7:6] == 2'h0)
					case (paddr[3:2])
						2'h0: next_st.prdata = st.idx[paddr[5:4]];
						2'h1: next_st.prdata = st.mdf[paddr[5:4]];
						2'h2: next_st.prdata = st.len[paddr[5:4]];
						default: next_st.prdata = st.base[paddr[5:4]];
					endcase
				else if (paddr[11:8] == dsp_pkg::A_PTR[11:8] && paddr[7:5] == 3'h0)
					next_st.prdata = st.ptr[paddr[4:2]];
				else
					next_st.pslverr = 1'b1;
			end
		end
	end

	// one register stage holds everything; outputs come straight from it
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			st <= '0;
		else
			st <= next_st;
	end

	always_comb begin
		prdata = st.prdata;
		pready = st.pready;
		pslverr = st.pslverr;
	end
endmodule : dsp_compute_datapath

// ### design/dsp_pkg.sv
package dsp_pkg;
	localparam int DW    = 32;
	localparam int HW    = 16;
	localparam int BW    = 8;
	localparam int AW    = 40;
	localparam int NREG  = 8;
	localparam int NSET  = 4;
	localparam int NPTR  = 8;

	// apb map, one word per register
	localparam logic [11:0] A_CTRL   = 12'h000; // op/mode select
	localparam logic [11:0] A_OPS    = 12'h004; // operand selects
	localparam logic [11:0] A_IMM    = 12'h008; // instruction constant field
	localparam logic [11:0] A_GO     = 12'h00c; // write issues one instruction
	localparam logic [11:0] A_RES    = 12'h010; // last alu/shifter result
	localparam logic [11:0] A_ACC0L  = 12'h014;
	localparam logic [11:0] A_ACC0H  = 12'h018;
	localparam logic [11:0] A_ACC1L  = 12'h01c;
	localparam logic [11:0] A_ACC1H  = 12'h020;
	localparam logic [11:0] A_STAT   = 12'h024;
	localparam logic [11:0] A_ADDR0  = 12'h028;
	localparam logic [11:0] A_ADDR1  = 12'h02c;
	localparam logic [11:0] A_RF     = 12'h100; // eight data registers
	localparam logic [11:0] A_DAG    = 12'h200; // index/modify/length/base x4
	localparam logic [11:0] A_PTR    = 12'h300; // eight pointers

	typedef enum logic [4:0] {
		OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_NOT, OP_ADD2, OP_SUB2,
		OP_MUL32, OP_POPCNT, OP_EXTRACT, OP_SIGNBITS, OP_SAT16, OP_RND16,
		OP_DIVS, OP_MIN, OP_MAX, OP_ALIGN, OP_PACK, OP_ADDCLIP8, OP_ADDCLIP16,
		OP_AVG8, OP_SUBTRACT_ABSOLUTE_ACCUMULATE, OP_SEARCH, OP_SHL, OP_ASHR, OP_ROT,
		OP_NORM, OP_DEPOSIT,
		OP_MAC, OP_QUAD
	} op_t;

	typedef struct packed {
		logic       mac1En;   // second mac in parallel
		logic       sat;
		logic       rnd;
		logic       unsig;
		logic       useImm;
		logic       half;     // 16-bit operand width
		logic       byteW;    // 8-bit operand width
		op_t        op;
	} ctrl_t;

	typedef struct packed {
		logic [3:0] srcA;     // half index when half=1
		logic [3:0] srcB;
		logic [2:0] dst;
		logic [1:0] dagSet0;
		logic [1:0] dagSet1;
	} ops_t;

	localparam logic signed [AW-1:0] ACC_MAX = {1'b0, {(AW-1){1'b1}}};
	localparam logic signed [AW-1:0] ACC_MIN = {1'b1, {(AW-1){1'b0}}};
	localparam logic [DW-1:0] RND_HALF = 32'h0000_8000;
	localparam logic [AW-1:0] ACC_RND  = 40'h00_0000_8000;
endpackage : dsp_pkg

// ### design/mac_unit.sv
`timescale 1ns/1ps
module mac_unit (
	input  wire logic                  sat,
	input  wire logic                  rnd,
	input  wire logic                  unsig,
	input  wire logic [15:0]           a,
	input  wire logic [15:0]           b,
	input  wire logic [39:0]           acc,
	output logic      [39:0]           accNext
);
	logic signed [40:0] prod;
	logic signed [41:0] sum;
	always_comb begin
		// one 16x16 product per cycle
		if (unsig)
			prod = 41'($unsigned(a) * $unsigned(b));
		else
			prod = 41'($signed(a) * $signed(b));
		sum = 42'($signed(acc)) + 42'(prod) + (rnd ? 42'(dsp_pkg::ACC_RND) : 42'h0);
		if (sat && sum > 42'(dsp_pkg::ACC_MAX))
			accNext = dsp_pkg::ACC_MAX;
		else if (sat && sum < 42'(dsp_pkg::ACC_MIN))
			accNext = dsp_pkg::ACC_MIN;
		else
			accNext = sum[39:0];
	end
endmodule : mac_unit

// ### tb/dsp_compute_datapath_properties.sv
`timescale 1ns/1ps
module dsp_compute_datapath_properties (
	input wire logic        clock,
	input wire logic        rstn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	logic mapped;
	logic ctrlOk;

	// word map: control block, register file, address sets, pointers
	always_comb begin
		// results and fetch addresses are read-only, the issue word write-only
		ctrlOk = pwrite ? (paddr <= dsp_pkg::A_GO || paddr == dsp_pkg::A_STAT)
			: (paddr <= dsp_pkg::A_ADDR1 && paddr != dsp_pkg::A_GO);
		mapped = (paddr[1:0] == 2'h0) && (ctrlOk
			|| (paddr >= dsp_pkg::A_RF && paddr <= 12'h11c)
			|| (paddr >= dsp_pkg::A_DAG && paddr <= 12'h23c)
			|| (paddr >= dsp_pkg::A_PTR && paddr <= 12'h31c));
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);

	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held past one cycle");
	chk_ready_phase: assert property (pready |-> psel && penable)
		else $error("pready outside an access phase");
	// stalls add one cycle, so four covers the worst answer
	chk_ready_bound: assert property (psel && penable && !pready |-> ##[1:4] pready)
		else $error("access not answered in time");
	chk_setup_quiet: assert property (psel && !penable |-> !pready)
		else $error("pready during setup cycle");
	chk_err_mapped: assert property (pready && mapped |-> !pslverr)
		else $error("error on a mapped register");
	chk_err_unmapped: assert property (pready && !mapped |-> pslverr)
		else $error("no error on an unmapped address");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	chk_unmapped_zero: assert property (pready && !mapped && !pwrite |-> prdata == 32'h0)
		else $error("unmapped read not zero");
endmodule : dsp_compute_datapath_properties

// ### tb/test_dsp_compute_datapath.sv
`timescale 1ns/1ps
module test_dsp_compute_datapath;
	typedef struct packed {
		dsp_pkg::op_t op;
		logic [1:0]   w;     // half, byte operand width
		logic         imm;
		logic [31:0]  a;
		logic [31:0]  b;
		logic [31:0]  k;
		logic [31:0]  exp;
	} row_t;

	logic                clock = 1'b0;
	logic                rstn = 1'b0;
	logic                psel = 1'b0;
	logic                penable = 1'b0;
	logic                pwrite = 1'b0;
	logic [11:0]         paddr = 12'h000;
	logic [31:0]         pwdata = 32'h0;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	int                  n_errors = 0;
	int                  tests_run = 0;
	row_t                rows [19];
	dsp_pkg::ctrl_t      cv;
	dsp_pkg::ops_t       ov;
	logic [31:0]         rd;
	logic                er;

	always #50 clock = ~clock;

	dsp_compute_datapath dut_u (
		.clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
	);

	task close_out;
		$display("errors=%0d checks=%0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out

	task cmp(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	// request held until pready is seen at an edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clock);
			if (pready === 1'b1)
				break;
		end
		if (i == 20) begin
			n_errors++;
			close_out();
		end else begin
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask : apb

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		cmp(rd, exp);
	endtask : rdchk

	initial begin
		repeat (10) @(posedge clock);
		rstn <= 1'b1;
		rdchk(dsp_pkg::A_RF + 12'h004, 32'h0);
		rdchk(dsp_pkg::A_STAT, 32'h0);
		rows[0] = '{dsp_pkg::OP_ADD, 2'h0, 1'b0, 32'h7fff_fff0, 32'h0000_0020, 32'h0,
			32'h7fff_fff0 + 32'h0000_0020};
		rows[1] = '{dsp_pkg::OP_SUB, 2'h0, 1'b0, 32'h0000_0010, 32'h0000_0020, 32'h0,
			32'h0000_0010 - 32'h0000_0020};
		rows[2] = '{dsp_pkg::OP_AND, 2'h0, 1'b0, 32'hf0f0_1234, 32'h0ff0_ff00, 32'h0,
			32'hf0f0_1234 & 32'h0ff0_ff00};
		rows[3] = '{dsp_pkg::OP_XOR, 2'h0, 1'b0, 32'hf0f0_1234, 32'h0ff0_ff00, 32'h0,
			32'hf0f0_1234 ^ 32'h0ff0_ff00};
		rows[4] = '{dsp_pkg::OP_MUL32, 2'h0, 1'b0, 32'h0001_0003, 32'h0003_0005, 32'h0,
			32'h0001_0003 * 32'h0003_0005};
		rows[5] = '{dsp_pkg::OP_ADD, 2'h0, 1'b1, 32'h0000_1000, 32'h0000_0777, 32'h0000_0005,
			32'h0000_1005};
		// half rows read low halves of regs 1 and 3, byte rows low bytes of regs 2 and 6
		rows[6] = '{dsp_pkg::OP_ADD, 2'h2, 1'b0, 32'habcd_1234, 32'h9999_0101, 32'h0,
			32'h0000_1335};
		rows[7] = '{dsp_pkg::OP_ADD, 2'h1, 1'b0, 32'hffff_ff12, 32'heeee_ee34, 32'h0,
			32'h0000_0046};
		rows[8] = '{dsp_pkg::OP_ADD2, 2'h0, 1'b0, 32'h0001_fffe, 32'h0002_0003, 32'h0,
			32'h0003_0001};
		rows[9] = '{dsp_pkg::OP_POPCNT, 2'h0, 1'b0, 32'hf0f0_0001, 32'h0, 32'h0,
			32'h0000_0009};
		rows[10] = '{dsp_pkg::OP_SHL, 2'h0, 1'b0, 32'h0000_0003, 32'h0000_0004, 32'h0,
			32'h0000_0030};
		rows[11] = '{dsp_pkg::OP_MIN, 2'h0, 1'b0, 32'hffff_fff0, 32'h0000_0005, 32'h0,
			32'hffff_fff0};
		rows[12] = '{dsp_pkg::OP_AVG8, 2'h0, 1'b0, 32'h0203_ff00, 32'h0404_ff01, 32'h0,
			32'h0304_ff01};
		rows[13] = '{dsp_pkg::OP_ADDCLIP8, 2'h0, 1'b0, 32'hf010_8001, 32'h2010_8001, 32'h0,
			32'hff20_ff02};
		rows[14] = '{dsp_pkg::OP_ROT, 2'h0, 1'b0, 32'h8000_0001, 32'h0000_0004, 32'h0,
			32'h0000_0018};
		// byte distances 5, 8, 7 and 0 land on top of the rotate result
		rows[15] = '{dsp_pkg::OP_SUBTRACT_ABSOLUTE_ACCUMULATE, 2'h0, 1'b0, 32'h0510_0a00,
			32'h0a08_0300, 32'h0, 32'h0000_002c};
		rows[16] = '{dsp_pkg::OP_SIGNBITS, 2'h0, 1'b0, 32'h0000_ffff, 32'h0, 32'h0,
			32'h0000_000f};
		rows[17] = '{dsp_pkg::OP_EXTRACT, 2'h0, 1'b0, 32'h0000_ab00, 32'h0000_0808, 32'h0,
			32'h0000_00ab};
		rows[18] = '{dsp_pkg::OP_PACK, 2'h0, 1'b0, 32'h1122_3344, 32'h5566_7788, 32'h0,
			32'h2244_6688};
		// a in regs 1 and 2, b in 3 and 6: either reading of a 32-bit select finds them
		foreach (rows[i]) begin
			cv = '0;
			cv.op = rows[i].op;
			cv.useImm = rows[i].imm;
			cv.half = rows[i].w[1];
			cv.byteW = rows[i].w[0];
			ov = '0;
			ov.srcA = 4'h2;
			ov.srcB = 4'h6;
			ov.dst = 3'h4;
			wr(dsp_pkg::A_RF + 12'h004, rows[i].a);
			wr(dsp_pkg::A_RF + 12'h008, rows[i].a);
			wr(dsp_pkg::A_RF + 12'h00c, rows[i].b);
			wr(dsp_pkg::A_RF + 12'h018, rows[i].b);
			wr(dsp_pkg::A_CTRL, {20'h0, cv});
			wr(dsp_pkg::A_OPS, {17'h0, ov});
			wr(dsp_pkg::A_IMM, rows[i].k);
			wr(dsp_pkg::A_GO, 32'h1);
			rdchk(dsp_pkg::A_RES, rows[i].exp);
			rdchk(dsp_pkg::A_RF + 12'h010, rows[i].exp);
		end
		apb(1'b0, 12'hffc, 32'h0);
		cmp({31'h0, er}, 32'h1);
		cmp(rd, 32'h0);
		apb(1'b1, 12'h0fc, 32'hffff_ffff);
		cmp({31'h0, er}, 32'h1);
		apb(1'b1, dsp_pkg::A_RES, 32'h1);
		cmp({31'h0, er}, 32'h1);
		apb(1'b0, dsp_pkg::A_RF + 12'h001, 32'h0);
		cmp({31'h0, er}, 32'h1);
		apb(1'b0, dsp_pkg::A_STAT, 32'h0);
		cmp({31'h0, er}, 32'h0);
		// second reset clears the accumulators before the saturation run
		rstn <= 1'b0;
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		for (int i = 0; i < 8; i++)
			wr(dsp_pkg::A_RF + 12'(4 * i), 32'h8000_8000);
		cv = '0;
		cv.op = dsp_pkg::OP_MAC;
		cv.sat = 1'b1;
		wr(dsp_pkg::A_CTRL, {20'h0, cv});
		wr(dsp_pkg::A_GO, 32'h1);
		rdchk(dsp_pkg::A_ACC0L, 32'h4000_0000);
		rdchk(dsp_pkg::A_ACC0H, 32'h0);
		// 512 products of 2^30 pass the 40-bit positive limit
		repeat (519) wr(dsp_pkg::A_GO, 32'h1);
		rdchk(dsp_pkg::A_ACC0L, 32'hffff_ffff);
		rdchk(dsp_pkg::A_ACC0H, 32'h0000_007f);
		wr(dsp_pkg::A_DAG, 32'h100);
		wr(dsp_pkg::A_DAG + 12'h004, 32'h4);
		wr(dsp_pkg::A_DAG + 12'h008, 32'h8);
		wr(dsp_pkg::A_DAG + 12'h00c, 32'h100);
		wr(dsp_pkg::A_DAG + 12'h010, 32'h400);
		wr(dsp_pkg::A_DAG + 12'h014, 32'h8);
		ov = '0;
		ov.dagSet1 = 2'h1;
		wr(dsp_pkg::A_OPS, {17'h0, ov});
		for (int i = 0; i < 3; i++) begin
			wr(dsp_pkg::A_GO, 32'h1);
			rdchk(dsp_pkg::A_ADDR0, 32'h100 + 32'(4 * (i % 2)));
			rdchk(dsp_pkg::A_ADDR1, 32'h400 + 32'(8 * i));
		end
		// unsigned, rounded, unsaturated: acc0 wraps, acc1 takes its first product
		cv = '0;
		cv.op = dsp_pkg::OP_MAC;
		cv.mac1En = 1'b1;
		cv.unsig = 1'b1;
		cv.rnd = 1'b1;
		wr(dsp_pkg::A_CTRL, {20'h0, cv});
		wr(dsp_pkg::A_GO, 32'h1);
		rdchk(dsp_pkg::A_ACC0L, 32'h4000_7fff);
		rdchk(dsp_pkg::A_ACC0H, 32'h0000_0080);
		rdchk(dsp_pkg::A_ACC1L, 32'h4000_8000);
		rdchk(dsp_pkg::A_ACC1H, 32'h0);
		// two negative products push the wrapped sum past the negative limit
		ov = '0;
		ov.srcB = 4'h1;
		wr(dsp_pkg::A_RF + 12'h004, 32'h7fff_7fff);
		wr(dsp_pkg::A_OPS, {17'h0, ov});
		cv = '0;
		cv.op = dsp_pkg::OP_MAC;
		cv.sat = 1'b1;
		wr(dsp_pkg::A_CTRL, {20'h0, cv});
		wr(dsp_pkg::A_GO, 32'h1);
		rdchk(dsp_pkg::A_ACC0L, 32'h0000_ffff);
		wr(dsp_pkg::A_GO, 32'h1);
		rdchk(dsp_pkg::A_ACC0L, 32'h0);
		rdchk(dsp_pkg::A_ACC0H, 32'h0000_0080);
		close_out();
	end
endmodule : test_dsp_compute_datapath

bind dsp_compute_datapath dsp_compute_datapath_properties chk_u (
	.clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
);
